// file: core/mdb_map.svh
// Named constants of the mobile DDR bank command decoder: pin encodings, widths and default cycle counts.
// Included by the package and by every design file; holds definitions only.
`ifndef MDB_MAP_SVH
`define MDB_MAP_SVH

// Bank address width and the width of every delay counter.
`define MDB_BA_W      2
`define MDB_CNT_W     8

// RAS, CAS and WE levels of each command while chip select is low.
`define MDB_ENC_NOP   3'h7
`define MDB_ENC_ACT   3'h3
`define MDB_ENC_RD    3'h5
`define MDB_ENC_WR    3'h4
`define MDB_ENC_BST   3'h6
`define MDB_ENC_PRE   3'h2
`define MDB_ENC_REF   3'h1
`define MDB_ENC_MRS   3'h0

// Default delays in clock cycles at 40 MHz.
`define MDB_RCD_CYC   3
`define MDB_RP_CYC    3
`define MDB_RFC_CYC   8
`define MDB_MRD_CYC   2
`define MDB_XP_CYC    2
`define MDB_XSR_CYC   12
`define MDB_BURST_CYC 2

`endif

// file: core/mdb_pkg.sv
// Types and the command decoder shared by the bank and top modules.
// Assumes mdb_map.svh is on the include path.
`include "mdb_map.svh"

package mdb_pkg;

  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_BST, OP_PRE, OP_REF, OP_MRS} mdb_op_e;

  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_PRECHARGING, BK_RD_AP, BK_WR_AP
  } mdb_bank_e;

  typedef enum logic [2:0] {
    PW_RUN, PW_REFRESH, PW_MODE_LOAD, PW_PDOWN, PW_SREF, PW_DPD, PW_PD_EXIT, PW_SR_EXIT
  } mdb_pwr_e;

  typedef struct packed {
    mdb_op_e op;
    logic    ap;
  } mdb_cmd_s;

  typedef struct packed {
    mdb_bank_e              st;
    logic [`MDB_CNT_W-1:0]  cnt;
  } mdb_bank_state_s;

  typedef struct packed {
    mdb_pwr_e               g_st;
    logic [`MDB_CNT_W-1:0]  g_cnt;
    logic                   cke_prev;
    logic [`MDB_BA_W-1:0]   last_rd;
    logic                   illegal;
  } mdb_top_state_s;

  // Chip select high is a deselect, which acts exactly like a NOP.
  function automatic mdb_op_e mdb_decode(input logic cs_n, input logic [2:0] rcw);
    mdb_op_e op;
    op = OP_NOP;
    if (!cs_n) begin
      unique case (rcw)
        `MDB_ENC_NOP: op = OP_NOP;
        `MDB_ENC_ACT: op = OP_ACT;
        `MDB_ENC_RD:  op = OP_RD;
        `MDB_ENC_WR:  op = OP_WR;
        `MDB_ENC_BST: op = OP_BST;
        `MDB_ENC_PRE: op = OP_PRE;
        `MDB_ENC_REF: op = OP_REF;
        `MDB_ENC_MRS: op = OP_MRS;
      endcase
    end
    return op;
  endfunction : mdb_decode

endpackage : mdb_pkg

// file: core/mdb_bank.sv
// One bank's state machine with its own delay counter.
// Assumes the top presents one decoded command per cycle, with sel marking the banks it addresses.
`timescale 1ns/1ps
`include "mdb_map.svh"

module mdb_bank
  import mdb_pkg::*;
#(
  parameter int RCD_CYC   = `MDB_RCD_CYC,
  parameter int RP_CYC    = `MDB_RP_CYC,
  parameter int BURST_CYC = `MDB_BURST_CYC
) (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // Command addressed to this bank
  input  wire mdb_cmd_s cmd,
  input  wire logic     sel,
  // Bank status
  output mdb_bank_e     state,
  output logic          legal
);

  localparam int AP_CYC  = BURST_CYC + RP_CYC;
  localparam int RCD_LIM = RCD_CYC;
  localparam int RP_LIM  = RP_CYC;
  localparam int AP_LIM  = AP_CYC;

  if (RCD_CYC < 1 || RP_CYC < 1 || BURST_CYC < 1 || AP_CYC >= (1 << `MDB_CNT_W)) begin : g_bad_param
    $error("mdb_bank: delay counts out of counter range");
  end

  mdb_bank_state_s st_ff;
  mdb_bank_state_s nxt_st;

  function automatic logic row_open(input mdb_bank_e s);
    return (s == BK_ACTIVE) || (s == BK_READ) || (s == BK_WRITE);
  endfunction : row_open

  function automatic logic [`MDB_CNT_W-1:0] load(input int n);
    return `MDB_CNT_W'(n - 1);
  endfunction : load

  always_comb begin
    nxt_st = st_ff;
    legal  = 1'b1;
    if (st_ff.cnt != '0) nxt_st.cnt = st_ff.cnt - 1'b1;
    unique case (st_ff.st)
      BK_ACTIVATING, BK_READ, BK_WRITE: if (st_ff.cnt == '0) nxt_st.st = BK_ACTIVE;
      BK_PRECHARGING, BK_RD_AP, BK_WR_AP: if (st_ff.cnt == '0) nxt_st.st = BK_IDLE;
      BK_IDLE, BK_ACTIVE: ;
    endcase
    if (sel) begin
      unique case (cmd.op)
        OP_ACT: begin
          if (st_ff.st == BK_IDLE) begin
            nxt_st.st  = BK_ACTIVATING;
            nxt_st.cnt = load(RCD_CYC);
          end else legal = 1'b0;
        end
        OP_RD, OP_WR: begin
          // A write into a running read is accepted; ending the read first is the controller's duty.
          if (row_open(st_ff.st)) begin
            if (cmd.ap) nxt_st.st = (cmd.op == OP_RD) ? BK_RD_AP : BK_WR_AP;
            else nxt_st.st = (cmd.op == OP_RD) ? BK_READ : BK_WRITE;
            nxt_st.cnt = load(cmd.ap ? AP_CYC : BURST_CYC);
          end else legal = 1'b0;
        end
        OP_PRE: begin
          if (row_open(st_ff.st)) begin
            nxt_st.st  = BK_PRECHARGING;
            nxt_st.cnt = load(RP_CYC);
          end else if (st_ff.st != BK_IDLE) legal = 1'b0;
        end
        OP_BST: begin
          if (st_ff.st == BK_READ) begin
            nxt_st.st  = BK_ACTIVE;
            nxt_st.cnt = '0;
          end else legal = 1'b0;
        end
        OP_NOP, OP_REF, OP_MRS: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) st_ff <= '{st: BK_IDLE, cnt: '0};
    else st_ff <= nxt_st;
  end

  assign state = st_ff.st;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  act_delay_a: assert property ((sel && cmd.op == OP_ACT && state == BK_IDLE) |=>
    (state == BK_ACTIVATING)[*1] ##(RCD_LIM - 1) (state == BK_ACTIVATING) ##1 (state == BK_ACTIVE))
    else $error("activate delay wrong");
  pre_idle_a: assert property ((sel && cmd.op == OP_PRE && row_open(state)) |=>
    (state == BK_PRECHARGING) ##RP_LIM (state == BK_IDLE))
    else $error("precharge period wrong");
  ap_idle_a: assert property ((sel && cmd.op == OP_RD && cmd.ap && row_open(state)) |=>
    (state == BK_RD_AP) ##AP_LIM (state == BK_IDLE))
    else $error("auto precharge end wrong");
  rd_start_a: assert property ((sel && cmd.op == OP_RD && !cmd.ap && row_open(state)) |=>
    (state == BK_READ)) else $error("read burst not started");
  wr_start_a: assert property ((sel && cmd.op == OP_WR && !cmd.ap && row_open(state)) |=>
    (state == BK_WRITE)) else $error("write burst not started");

endmodule : mdb_bank

// file: core/mdb_cmd_fsm.sv
// Command state machine of a mobile DDR SDRAM: decodes the command pins each edge and tracks banks and power.
// Assumes the pins are synchronous to clk and that the controller keeps the waits it is responsible for.
`timescale 1ns/1ps
`include "mdb_map.svh"

module mdb_cmd_fsm
  import mdb_pkg::*;
#(
  parameter int NUM_BANKS = 1 << `MDB_BA_W,
  parameter int RCD_CYC   = `MDB_RCD_CYC,
  parameter int RP_CYC    = `MDB_RP_CYC,
  parameter int RFC_CYC   = `MDB_RFC_CYC,
  parameter int MRD_CYC   = `MDB_MRD_CYC,
  parameter int XP_CYC    = `MDB_XP_CYC,
  parameter int XSR_CYC   = `MDB_XSR_CYC,
  parameter int BURST_CYC = `MDB_BURST_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Command pins from the controller
  input  wire logic                 cs_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic                 cke,
  input  wire logic [`MDB_BA_W-1:0] ba,
  input  wire logic                 precharge_select_bit,
  // Device status
  output mdb_bank_e                 bank_state [NUM_BANKS],
  output mdb_pwr_e                  pwr_state,
  output logic                      all_banks_idle,
  output logic                      illegal_seq,
  output logic [`MDB_BA_W-1:0]      last_read_bank
);

  localparam int RFC_LIM = RFC_CYC;
  localparam int MRD_LIM = MRD_CYC;
  localparam int XP_LIM  = XP_CYC;
  localparam int XSR_LIM = XSR_CYC;

  if (NUM_BANKS != (1 << `MDB_BA_W) || RFC_CYC < 1 || MRD_CYC < 1 || XP_CYC < 1 || XSR_CYC < 1 ||
      RFC_CYC >= (1 << `MDB_CNT_W) || XSR_CYC >= (1 << `MDB_CNT_W) || XP_CYC >= (1 << `MDB_CNT_W) ||
      MRD_CYC >= (1 << `MDB_CNT_W)) begin : g_bad_param
    $error("mdb_cmd_fsm: bank count or delay counts unsupported");
  end

  mdb_top_state_s         st_ff;
  mdb_top_state_s         nxt_st;
  mdb_op_e                op;
  mdb_cmd_s               bank_cmd;
  logic [NUM_BANKS-1:0]   bank_sel;
  logic [NUM_BANKS-1:0]   bank_legal;
  logic [NUM_BANKS-1:0]   bank_idle;
  logic [NUM_BANKS-1:0]   bank_done;
  logic                   cmd_run;
  logic                   bad;

  function automatic logic [NUM_BANKS-1:0] one_bank(input logic [`MDB_BA_W-1:0] b);
    return NUM_BANKS'(1) << b;
  endfunction : one_bank

  function automatic logic [`MDB_CNT_W-1:0] load(input int n);
    return `MDB_CNT_W'(n - 1);
  endfunction : load

  assign op       = mdb_decode(cs_n, {ras_n, cas_n, we_n});
  assign bank_cmd = '{op: op, ap: precharge_select_bit};
  // Bank commands only act with clock enable high at both edges and outside any timed global state.
  assign cmd_run  = (st_ff.g_st == PW_RUN) && st_ff.cke_prev && cke;

  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    mdb_bank #(
      .RCD_CYC   (RCD_CYC),
      .RP_CYC    (RP_CYC),
      .BURST_CYC (BURST_CYC)
    ) u_bank (
      .clk   (clk),
      .rst   (rst),
      .cmd   (bank_cmd),
      .sel   (bank_sel[i]),
      .state (bank_state[i]),
      .legal (bank_legal[i])
    );
    assign bank_idle[i] = (bank_state[i] == BK_IDLE);
    assign bank_done[i] = (bank_state[i] == BK_IDLE) || (bank_state[i] == BK_PRECHARGING);
  end

  assign all_banks_idle = &bank_idle;

  always_comb begin
    nxt_st          = st_ff;
    bad             = 1'b0;
    bank_sel        = '0;
    nxt_st.cke_prev = cke;
    if (st_ff.g_cnt != '0) nxt_st.g_cnt = st_ff.g_cnt - 1'b1;
    if (st_ff.cke_prev && cke) begin
      unique case (st_ff.g_st)
        PW_RUN: begin
          unique case (op)
            OP_NOP: ;
            OP_ACT, OP_RD, OP_WR: bank_sel = one_bank(ba);
            OP_PRE: bank_sel = precharge_select_bit ? {NUM_BANKS{1'b1}} : one_bank(ba);
            OP_BST: bank_sel = one_bank(st_ff.last_rd);
            OP_REF, OP_MRS: begin
              if (all_banks_idle) begin
                nxt_st.g_st  = (op == OP_REF) ? PW_REFRESH : PW_MODE_LOAD;
                nxt_st.g_cnt = load((op == OP_REF) ? RFC_CYC : MRD_CYC);
              end else bad = 1'b1;
            end
          endcase
          if (op == OP_RD) nxt_st.last_rd = ba;
        end
        PW_REFRESH, PW_MODE_LOAD, PW_PD_EXIT, PW_SR_EXIT: begin
          // The device reports early commands but keeps counting; the controller owns these waits.
          if (op != OP_NOP) bad = 1'b1;
          if (st_ff.g_cnt == '0) nxt_st.g_st = PW_RUN;
        end
        PW_PDOWN, PW_SREF, PW_DPD: bad = 1'b1;
      endcase
    end else if (st_ff.cke_prev && !cke) begin
      if (st_ff.g_st != PW_RUN) bad = 1'b1;
      else if (op == OP_NOP) nxt_st.g_st = PW_PDOWN;
      else if (op == OP_REF && all_banks_idle) nxt_st.g_st = PW_SREF;
      else if (op == OP_BST && all_banks_idle) nxt_st.g_st = PW_DPD;
      else bad = 1'b1;
    end else if (!st_ff.cke_prev && cke) begin
      if (op != OP_NOP) bad = 1'b1;
      if (st_ff.g_st == PW_PDOWN) begin
        nxt_st.g_st  = PW_PD_EXIT;
        nxt_st.g_cnt = load(XP_CYC);
      end else if (st_ff.g_st == PW_SREF) begin
        nxt_st.g_st  = PW_SR_EXIT;
        nxt_st.g_cnt = load(XSR_CYC);
      end else if (st_ff.g_st == PW_DPD) nxt_st.g_st = PW_RUN;
    end
    // A bank that refuses precharge-all is reported, yet the banks that accept it still precharge.
    if (|(bank_sel & ~bank_legal)) bad = 1'b1;
    nxt_st.illegal = bad;
  end

  // Clock enable counts as low before reset ends, so the first edge after reset cannot enter power-down.
  always_ff @(posedge clk) begin
    if (rst) st_ff <= '{g_st: PW_RUN, g_cnt: '0, cke_prev: 1'b0, last_rd: '0, illegal: 1'b0};
    else st_ff <= nxt_st;
  end

  assign pwr_state      = st_ff.g_st;
  assign illegal_seq    = st_ff.illegal;
  assign last_read_bank = st_ff.last_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pd_entry_a: assert property ((cmd_run == 1'b0 && pwr_state == PW_RUN && st_ff.cke_prev && !cke &&
    op == OP_NOP) |=> (pwr_state == PW_PDOWN)) else $error("power-down entry missed");
  nop_quiet_a: assert property ((cmd_run && op == OP_NOP) |=>
    (!illegal_seq && pwr_state == PW_RUN && last_read_bank == $past(last_read_bank)))
    else $error("NOP disturbed state");
  refresh_time_a: assert property ((cmd_run && op == OP_REF && all_banks_idle) |=>
    (pwr_state == PW_REFRESH) ##RFC_LIM (pwr_state == PW_RUN)) else $error("refresh time wrong");
  mode_time_a: assert property ((cmd_run && op == OP_MRS && all_banks_idle) |=>
    (pwr_state == PW_MODE_LOAD) ##MRD_LIM (pwr_state == PW_RUN)) else $error("mode load time wrong");
  busy_cmd_a: assert property ((st_ff.cke_prev && cke && pwr_state == PW_REFRESH && op != OP_NOP) |=>
    illegal_seq) else $error("command during refresh not flagged");
  bst_route_a: assert property ((cmd_run && op == OP_BST && bank_state[last_read_bank] == BK_READ) |=>
    (bank_state[$past(last_read_bank)] == BK_ACTIVE && !illegal_seq)) else $error("terminate misrouted");
  pre_all_a: assert property ((cmd_run && op == OP_PRE && precharge_select_bit && &bank_legal) |=>
    (&bank_done)) else $error("precharge all missed a bank");
  sref_entry_a: assert property ((pwr_state == PW_RUN && st_ff.cke_prev && !cke && op == OP_REF &&
    all_banks_idle) |=> (pwr_state == PW_SREF)) else $error("self refresh entry missed");
  ref_busy_a: assert property ((cmd_run && op == OP_REF && !all_banks_idle) |=>
    (illegal_seq && pwr_state == PW_RUN)) else $error("refresh with open bank not refused");
  dpd_entry_a: assert property ((pwr_state == PW_RUN && st_ff.cke_prev && !cke && op == OP_BST &&
    all_banks_idle) |=> (pwr_state == PW_DPD)) else $error("deep power-down entry missed");
  // The exit checks rely on the controller holding clock enable high through the whole wait.
  pd_exit_a: assert property ((pwr_state == PW_PDOWN && !st_ff.cke_prev && cke) |=>
    (pwr_state == PW_PD_EXIT) ##XP_LIM (pwr_state == PW_RUN))
    else $error("power-down exit time wrong");
  sr_exit_a: assert property ((pwr_state == PW_SREF && !st_ff.cke_prev && cke) |=>
    (pwr_state == PW_SR_EXIT) ##XSR_LIM (pwr_state == PW_RUN))
    else $error("self refresh exit time wrong");
  dpd_exit_a: assert property ((pwr_state == PW_DPD && !st_ff.cke_prev && cke) |=>
    (pwr_state == PW_RUN)) else $error("deep power-down exit missed");
  last_rd_a: assert property ((cmd_run && op == OP_RD) |=> (last_read_bank == $past(ba)))
    else $error("read bank not recorded");
  act_refuse_a: assert property ((cmd_run && op == OP_ACT && bank_state[ba] != BK_IDLE) |=>
    illegal_seq) else $error("activate to busy bank not flagged");

  refresh_c: cover property (cmd_run && op == OP_REF && all_banks_idle);
  bst_c: cover property (cmd_run && op == OP_BST && bank_state[last_read_bank] == BK_READ);
  sref_exit_c: cover property (pwr_state == PW_SR_EXIT ##1 pwr_state == PW_RUN);
  illegal_c: cover property (illegal_seq);
  pd_exit_c: cover property (pwr_state == PW_PD_EXIT ##1 pwr_state == PW_RUN);

endmodule : mdb_cmd_fsm

// file: testbench/mdb_ctrl_model.sv
// Behavioural memory-controller model that drives the command, bank and clock-enable pins.
// Assumes the bench calls its tasks in sequence and keeps every wait that the device needs.
`timescale 1ns/1ps
`include "mdb_map.svh"

module mdb_ctrl_model
  import mdb_pkg::*;
(
  // Clock
  input  wire logic                 clk,
  // Command pins toward the device
  output logic                      cs_n,
  output logic                      ras_n,
  output logic                      cas_n,
  output logic                      we_n,
  output logic                      cke,
  output logic [`MDB_BA_W-1:0]      ba,
  output logic                      precharge_select_bit
);
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = `MDB_ENC_NOP;
    cke = 1'b1;
    ba = 2'h0;
    precharge_select_bit = 1'b0;
  end

  // One command per call, launched just after a rising edge and held for that cycle only.
  task automatic send(input logic [2:0] rcw, input logic [`MDB_BA_W-1:0] b, input logic a, input logic k);
    @(posedge clk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= rcw;
    ba <= b;
    precharge_select_bit <= a;
    cke <= k;
  endtask : send

  // Deselect for one cycle. Released lines flip so that a stale value never passes for a valid one.
  // The clock is never stopped, so it toggles through every exit wait.
  task automatic idle(input logic k);
    @(posedge clk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
    ba <= ~ba;
    precharge_select_bit <= ~precharge_select_bit;
    cke <= k;
  endtask : idle
endmodule : mdb_ctrl_model

// file: testbench/mobile_ddr_bank_command_fsm_test.sv
// Self-checking bench of the bank command machine; each scenario drives pins through the controller model.
// Assumes a 40 MHz clock and the design's default delays except a longer burst.
`timescale 1ns/1ps
`include "mdb_map.svh"

module mobile_ddr_bank_command_fsm_test
  import mdb_pkg::*;
();
  localparam int BURST = 4;
  localparam int RCD   = `MDB_RCD_CYC;
  localparam int RP    = `MDB_RP_CYC;

  logic                 clk;
  logic                 rst;
  logic                 cs_n;
  logic                 ras_n;
  logic                 cas_n;
  logic                 we_n;
  logic                 cke;
  logic [`MDB_BA_W-1:0] ba;
  logic                 psel;
  mdb_bank_e            bank_state [4];
  mdb_pwr_e             pwr_state;
  logic                 all_banks_idle;
  logic                 illegal_seq;
  logic [`MDB_BA_W-1:0] last_read_bank;
  int                   error_cnt;
  int                   compares;

  mdb_ctrl_model u_ctl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
    .ba(ba), .precharge_select_bit(psel));

  mdb_cmd_fsm #(.BURST_CYC(BURST)) u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .cke(cke), .ba(ba), .precharge_select_bit(psel), .bank_state(bank_state),
    .pwr_state(pwr_state), .all_banks_idle(all_banks_idle), .illegal_seq(illegal_seq),
    .last_read_bank(last_read_bank));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : cmp

  task automatic chk_b(input int b, input mdb_bank_e exp);
    @(negedge clk);
    cmp("bank_state", exp, bank_state[b]);
  endtask : chk_b

  task automatic hold_b(input int n, input int b, input mdb_bank_e exp);
    repeat (n) begin
      u_ctl.idle(1'b1);
      chk_b(b, exp);
    end
  endtask : hold_b

  task automatic hold_p(input int n, input mdb_pwr_e exp, input logic k);
    repeat (n) begin
      u_ctl.idle(k);
      @(negedge clk);
      cmp("pwr_state", exp, pwr_state);
    end
  endtask : hold_p

  task automatic open_row(input logic [1:0] b);
    u_ctl.send(`MDB_ENC_ACT, b, 1'b0, 1'b1);
    hold_b(RCD, b, BK_ACTIVATING);
    hold_b(1, b, BK_ACTIVE);
  endtask : open_row

  task automatic t_read();
    open_row(2'h0);
    u_ctl.send(`MDB_ENC_RD, 2'h0, 1'b0, 1'b1);
    u_ctl.send(`MDB_ENC_RD, 2'h0, 1'b0, 1'b1);
    chk_b(0, BK_READ);
    hold_b(BURST, 0, BK_READ);
    hold_b(1, 0, BK_ACTIVE);
    cmp("last_read_bank", 8'h00, last_read_bank);
    // The read burst has run out, so this write needs no terminate first.
    u_ctl.send(`MDB_ENC_WR, 2'h0, 1'b0, 1'b1);
    u_ctl.send(`MDB_ENC_PRE, 2'h0, 1'b0, 1'b1);
    chk_b(0, BK_WRITE);
    hold_b(RP, 0, BK_PRECHARGING);
    hold_b(1, 0, BK_IDLE);
  endtask : t_read

  // Only deselects reach the bank while its auto-precharge burst runs.
  task automatic t_read_ap();
    logic [2:0] enc [2]   = '{`MDB_ENC_RD, `MDB_ENC_WR};
    mdb_bank_e  ap_st [2] = '{BK_RD_AP, BK_WR_AP};
    for (int i = 0; i < 2; i++) begin
      open_row(2'h1);
      u_ctl.send(enc[i], 2'h1, 1'b1, 1'b1);
      hold_b(BURST + RP, 1, ap_st[i]);
      hold_b(1, 1, BK_IDLE);
    end
  endtask : t_read_ap

  task automatic t_write();
    open_row(2'h2);
    u_ctl.send(`MDB_ENC_WR, 2'h2, 1'b0, 1'b1);
    // The data mask is outside this block; the controller masks the write data this read cuts off.
    u_ctl.send(`MDB_ENC_RD, 2'h2, 1'b0, 1'b1);
    chk_b(2, BK_WRITE);
    u_ctl.send(`MDB_ENC_PRE, 2'h2, 1'b0, 1'b1);
    chk_b(2, BK_READ);
    hold_b(RP, 2, BK_PRECHARGING);
    hold_b(1, 2, BK_IDLE);
    open_row(2'h2);
    u_ctl.send(`MDB_ENC_WR, 2'h2, 1'b0, 1'b1);
    u_ctl.send(`MDB_ENC_PRE, 2'h2, 1'b0, 1'b1);
    chk_b(2, BK_WRITE);
    hold_b(RP, 2, BK_PRECHARGING);
    hold_b(1, 2, BK_IDLE);
  endtask : t_write

  task automatic t_bst();
    open_row(2'h0);
    open_row(2'h1);
    u_ctl.send(`MDB_ENC_RD, 2'h0, 1'b0, 1'b1);
    u_ctl.send(`MDB_ENC_RD, 2'h1, 1'b0, 1'b1);
    chk_b(0, BK_READ);
    u_ctl.send(`MDB_ENC_BST, 2'h0, 1'b0, 1'b1);
    chk_b(1, BK_READ);
    hold_b(1, 1, BK_ACTIVE);
    cmp("bank_state", BK_READ, bank_state[0]);
    cmp("last_read_bank", 8'h01, last_read_bank);
    u_ctl.send(`MDB_ENC_PRE, 2'h2, 1'b1, 1'b1);
    hold_b(RP, 0, BK_PRECHARGING);
    cmp("bank_state", BK_PRECHARGING, bank_state[1]);
    hold_b(1, 0, BK_IDLE);
    cmp("all_banks_idle", 8'h01, all_banks_idle);
  endtask : t_bst

  task automatic t_illegal();
    u_ctl.send(`MDB_ENC_ACT, 2'h3, 1'b0, 1'b1);
    u_ctl.send(`MDB_ENC_ACT, 2'h3, 1'b0, 1'b1);
    chk_b(3, BK_ACTIVATING);
    u_ctl.idle(1'b1);
    chk_b(3, BK_ACTIVATING);
    cmp("illegal_seq", 8'h01, illegal_seq);
    u_ctl.send(`MDB_ENC_REF, 2'h0, 1'b0, 1'b1);
    @(negedge clk);
    cmp("illegal_seq", 8'h00, illegal_seq);
    hold_b(1, 3, BK_ACTIVE);
    cmp("illegal_seq", 8'h01, illegal_seq);
    cmp("pwr_state", PW_RUN, pwr_state);
    u_ctl.send(`MDB_ENC_PRE, 2'h3, 1'b0, 1'b1);
    hold_b(RP, 3, BK_PRECHARGING);
    hold_b(1, 3, BK_IDLE);
  endtask : t_illegal

  // Refresh and mode load are sent only with every bank idle.
  task automatic t_refresh();
    u_ctl.send(`MDB_ENC_REF, 2'h0, 1'b0, 1'b1);
    hold_p(`MDB_RFC_CYC, PW_REFRESH, 1'b1);
    hold_p(1, PW_RUN, 1'b1);
    cmp("all_banks_idle", 8'h01, all_banks_idle);
    u_ctl.send(`MDB_ENC_MRS, 2'h0, 1'b0, 1'b1);
    hold_p(`MDB_MRD_CYC, PW_MODE_LOAD, 1'b1);
    hold_p(1, PW_RUN, 1'b1);
  endtask : t_refresh

  task automatic t_power();
    logic [2:0] ent [3] = '{`MDB_ENC_NOP, `MDB_ENC_REF, `MDB_ENC_BST};
    mdb_pwr_e   low [3] = '{PW_PDOWN, PW_SREF, PW_DPD};
    mdb_pwr_e   ext [3] = '{PW_PD_EXIT, PW_SR_EXIT, PW_RUN};
    int         len [3] = '{`MDB_XP_CYC, `MDB_XSR_CYC, 0};
    for (int i = 0; i < 3; i++) begin
      u_ctl.send(ent[i], 2'h0, 1'b0, 1'b0);
      hold_p(3, low[i], 1'b0);
      u_ctl.send(`MDB_ENC_NOP, 2'h0, 1'b0, 1'b1);
      hold_p(len[i], ext[i], 1'b1);
      hold_p(1, PW_RUN, 1'b1);
    end
  endtask : t_power

  task automatic summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    hold_p(2, PW_RUN, 1'b1);
    cmp("all_banks_idle", 8'h01, all_banks_idle);
    cmp("illegal_seq", 8'h00, illegal_seq);
    t_read();
    t_read_ap();
    t_write();
    t_bst();
    t_illegal();
    t_refresh();
    t_power();
    summarize();
  end

  // The scenarios need well under a thousand cycles; this bound only catches a hang.
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : mobile_ddr_bank_command_fsm_test
